// ---- gpio_pad_model.sv ----
`timescale 1ns/1ps
// Pads with outside drivers and pull-ups
module gpio_pad_model (
   input  wire logic [7:0] pin_out,    // Port drive value
   input  wire logic [7:0] pin_oe,     // Port drive enable
   input  wire logic [7:0] pin_pullup, // Pull-up enable
   input  wire logic [7:0] ext_en,     // Outside driver on
   input  wire logic [7:0] ext_val,    // Outside driver level
   input  wire logic       clock,      // Float pattern clock
   output logic      [7:0] pin_level   // Resolved level
);
   logic [7:0] drift = 8'h55;
   // Unpulled undriven pads wander
   always @(posedge clock)
   begin
      drift <= ~drift;
   end
   // Port wins, then outside, then pull
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                    | (~pin_oe & ~ext_en & (pin_pullup | drift));
endmodule

// ---- gpio_pkg.sv ----
// Contract
// - Eight pins; bit X of data, direction, option controls pin X independently.
// - Direction clear makes input; data read returns synchronised pin level.
// - Data write on an input pin updates only the latch.
// - Direction set makes output from latch; data read returns latch value.
// - Latch 0 drives low; latch 1 drives high push-pull, floats open-drain.
// - Direction/option 00 float, 01 pull-up, 10 open-drain, 11 push-pull.
// - Interrupt pins: dir 0 opt 1 is interrupt input; CPU mask gates request.
// - Each interrupt input pin raises requests by its own sensitivity setting; code uses one two-bit setting per vector group.
// - Per vector, detected events of enabled pins are ORed into one request.
// - Request latch clears on vector fetch or sensitivity change; not readable.
// - Peripheral use of a pin overrides direction, option and data settings.
// - Peripheral-driven pin is output, push-pull or open-drain per peripheral.
// - Input pin feeding a peripheral stays readable through data register.
// - Input pin with alternate output enabled reads the alternate output.
// - Output pin with alternate input enabled gives peripheral the latch.
// - Wait and halt leave ports alone; external interrupts wake the device.
package gpio_pkg;
   localparam int unsigned PIN_COUNT = 8;
   localparam int unsigned ADDR_W    = 2;
   localparam int unsigned GROUP_CNT = 2;
   // Register offsets
   localparam logic [1:0] OFF_DATA  = 2'h0;
   localparam logic [1:0] OFF_DIR   = 2'h1;
   localparam logic [1:0] OFF_OPT   = 2'h2;
   localparam logic [1:0] OFF_SENS  = 2'h3;
   // Reset values
   localparam logic [7:0] RST_DATA  = 8'h00;
   localparam logic [7:0] RST_DIR   = 8'h00;
   localparam logic [7:0] RST_OPT   = 8'h00;
   localparam logic [7:0] RST_SENS  = 8'h00;
   // Sensitivity field: two bits per vector group at bit 2*g
   localparam int unsigned SENS_W    = 2;

   // Detection encodings
   typedef enum logic [1:0] {
      GPIO_SENS_FALL_LOW = 2'b00,
      GPIO_SENS_RISE     = 2'b01,
      GPIO_SENS_FALL     = 2'b10,
      GPIO_SENS_BOTH     = 2'b11
   } gpio_sens_t;

   // Pin mode from direction/option pair
   typedef enum logic [1:0] {
      GPIO_MODE_FLOAT = 2'b00,
      GPIO_MODE_PULL  = 2'b01,
      GPIO_MODE_OD    = 2'b10,
      GPIO_MODE_PP    = 2'b11
   } gpio_mode_t;

   // Register bus request
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } gpio_bus_t;

   // Alternate function group, one bit per pin
   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] out_en;
      logic [7:0] out_val;
      logic [7:0] od;
   } gpio_alt_t;
endpackage

// ---- gpio_port.sv ----
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Eight-pin port with external interrupt grouping
module gpio_port #(
   parameter logic [7:0] IRQ_CAPABLE = 8'h0f,  // Pins that can interrupt
   parameter logic [7:0] IRQ_PULLUP  = 8'h0f,  // Interrupt pins with pull-up
   parameter logic [7:0] GROUP1_MAP  = 8'h0c   // Pins on vector 1, rest vector 0
) (
   input  wire logic                      clock,        // 100 MHz clock
   input  wire logic                      rst,          // Async reset, high
   input  wire logic                      ce,           // Clock enable
   input  wire logic [1:0]                addr,         // Register address
   input  wire logic [7:0]                wdata,        // Write data
   input  wire logic                      wr,           // Write strobe
   input  wire logic                      rd,           // Read strobe
   output logic      [7:0]                rdata,        // Read data, next cycle
   input  wire logic [7:0]                pin_in,       // Pad input levels
   output logic      [7:0]                pin_out,      // Pad output value
   output logic      [7:0]                pin_oe,       // Pad drive enable
   output logic      [7:0]                pin_pullup,   // Pad pull-up enable
   input  wire gpio_pkg::gpio_alt_t       alt,          // Peripheral pin use
   output logic      [7:0]                alt_in,       // Level to peripherals
   input  wire logic                      cpu_int_mask, // CPU interrupt mask
   input  wire logic [1:0]                vec_fetch,    // Vector fetch pulses
   output logic      [1:0]                irq_req,      // Masked requests
   output logic                           wake          // Wake from wait/halt
);
   logic [7:0] pin_data_latch_reg;
   logic [7:0] port_direction_reg;
   logic [7:0] port_option_reg;
   logic [7:0] ext_irq_sensitivity_ctrl_reg;
   logic [7:0] pin_sync;
   logic [7:0] pin_prev_reg;
   logic [1:0] pend_reg;
   logic [1:0] pend_next;
   logic [7:0] irq_en;
   logic [7:0] event_det;
   logic [7:0] read_view;
   logic [7:0] eff_dir;
   logic [7:0] eff_od;
   logic [7:0] eff_val;
   logic [1:0] group_evt;
   logic       sens_wr;

   // Mode of one pin from its direction and option bits
   function automatic gpio_pkg::gpio_mode_t pin_mode(input logic d, input logic o);
      pin_mode = gpio_pkg::gpio_mode_t'({d, o});
   endfunction

   // Event detection for one pin at given sensitivity
   function automatic logic detect(input logic cur, input logic prv, input logic [1:0] s);
      case (gpio_pkg::gpio_sens_t'(s))
         gpio_pkg::GPIO_SENS_FALL_LOW: detect = ~cur;
         gpio_pkg::GPIO_SENS_RISE:     detect = cur & ~prv;
         gpio_pkg::GPIO_SENS_FALL:     detect = ~cur & prv;
         gpio_pkg::GPIO_SENS_BOTH:     detect = cur ^ prv;
         default:                      detect = 1'b0;
      endcase
   endfunction

   // Pin level synchroniser
   gpio_sync #(
      .WIDTH (gpio_pkg::PIN_COUNT)
   ) u_sync (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .din   (pin_in),
      .dout  (pin_sync)
   );

   // Data latch: writes always land in the latch only
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pin_data_latch_reg <= gpio_pkg::RST_DATA;
      else if (ce && wr && addr == gpio_pkg::OFF_DATA)
         pin_data_latch_reg <= wdata;
   end

   // Direction register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         port_direction_reg <= gpio_pkg::RST_DIR;
      else if (ce && wr && addr == gpio_pkg::OFF_DIR)
         port_direction_reg <= wdata;
   end

   // Option register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         port_option_reg <= gpio_pkg::RST_OPT;
      else if (ce && wr && addr == gpio_pkg::OFF_OPT)
         port_option_reg <= wdata;
   end

   // Sensitivity register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         ext_irq_sensitivity_ctrl_reg <= gpio_pkg::RST_SENS;
      else if (ce && sens_wr)
         ext_irq_sensitivity_ctrl_reg <= wdata;
   end

   assign sens_wr = wr && addr == gpio_pkg::OFF_SENS;

   // Pad drive per pin; peripheral overrides standard settings
   generate
      for (genvar i = 0; i < 8; i++)
      begin : g_pin
         gpio_pkg::gpio_mode_t mode;
         assign mode = pin_mode(port_direction_reg[i], port_option_reg[i]);
         assign eff_dir[i] = (alt.sel[i] && alt.out_en[i]) ? 1'b1
                           : port_direction_reg[i];
         assign eff_od[i]  = (alt.sel[i] && alt.out_en[i]) ? alt.od[i]
                           : (mode == gpio_pkg::GPIO_MODE_OD);
         assign eff_val[i] = (alt.sel[i] && alt.out_en[i]) ? alt.out_val[i]
                           : pin_data_latch_reg[i];
         assign pin_out[i] = eff_val[i];
         // Drive low for 0; drive high only in push-pull
         assign pin_oe[i]  = eff_dir[i] & (~eff_val[i] | ~eff_od[i]);
         assign pin_pullup[i] = ~eff_dir[i] & (mode == gpio_pkg::GPIO_MODE_PULL)
                              & (~IRQ_CAPABLE[i] | IRQ_PULLUP[i]);
         // Interrupt input: direction 0, option 1 on capable pins
         assign irq_en[i] = IRQ_CAPABLE[i] & (mode == gpio_pkg::GPIO_MODE_PULL);
         // Peripheral sees latch when output, else pin level
         assign alt_in[i] = port_direction_reg[i] ? pin_data_latch_reg[i]
                          : pin_sync[i];
         // Read view per pin
         assign read_view[i] = port_direction_reg[i] ? pin_data_latch_reg[i]
                             : (alt.sel[i] && alt.out_en[i]) ? alt.out_val[i]
                             : pin_sync[i];
         assign event_det[i] = irq_en[i] & detect(pin_sync[i], pin_prev_reg[i],
            ext_irq_sensitivity_ctrl_reg[(GROUP1_MAP[i] ? 2 : 0) +: 2]);
      end
   endgenerate

   // Previous synced level for edge detection
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pin_prev_reg <= 8'hff;
      else if (ce)
         pin_prev_reg <= pin_sync;
   end

   // OR detected events per vector group
   assign group_evt[0] = |(event_det & ~GROUP1_MAP);
   assign group_evt[1] = |(event_det & GROUP1_MAP);

   // Request latch: set wins over clear
   always_comb
   begin
      pend_next = pend_reg;
      for (int g = 0; g < 2; g++)
      begin
         if (vec_fetch[g] || sens_wr)
            pend_next[g] = 1'b0;
         if (group_evt[g])
            pend_next[g] = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pend_reg <= 2'h0;
      else if (ce)
         pend_reg <= pend_next;
   end

   assign irq_req = cpu_int_mask ? 2'h0 : pend_reg;
   assign wake    = |irq_req;

   // Read data one cycle after strobe; request latch not mapped
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rdata <= 8'h00;
      else if (ce)
      begin
         if (rd)
         begin
            case (addr)
               gpio_pkg::OFF_DATA: rdata <= read_view;
               gpio_pkg::OFF_DIR:  rdata <= port_direction_reg;
               gpio_pkg::OFF_OPT:  rdata <= port_option_reg;
               gpio_pkg::OFF_SENS: rdata <= ext_irq_sensitivity_ctrl_reg;
               default:            rdata <= 8'h00;
            endcase
         end
         else
            rdata <= 8'h00;
      end
   end
endmodule

// ---- gpio_port_props.sv ----
`timescale 1ns/1ps
// Port-level properties of the pin port
module gpio_port_props (
   input wire logic                clock,        // Clock
   input wire logic                rst,          // Async reset
   input wire logic [1:0]          addr,         // Register address
   input wire logic                wr,           // Write strobe
   input wire logic                rd,           // Read strobe
   input wire logic [7:0]          rdata,        // Read data
   input wire logic [7:0]          pin_oe,       // Pad drive enable
   input wire logic [7:0]          pin_pullup,   // Pull-up enable
   input wire gpio_pkg::gpio_alt_t alt,          // Peripheral pin use
   input wire logic                cpu_int_mask, // Interrupt mask
   input wire logic [1:0]          vec_fetch,    // Vector fetch
   input wire logic [1:0]          irq_req,      // Requests
   input wire logic                wake          // Wake
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Request gating and wake
   a_mask_blocks: assert property (cpu_int_mask |-> irq_req == 2'h0)
      else $error("request seen while masked");
   a_wake_tracks: assert property (wake == (|irq_req))
      else $error("wake differs from requests");
   a_req_holds: assert property (irq_req[1] && !vec_fetch[1] && !(wr && addr == 2'h3)
      ##0 !cpu_int_mask |=> irq_req[1] || cpu_int_mask)
      else $error("pending request lost");
   // Peripheral drive of pads
   a_alt_pp: assert property ((alt.sel & alt.out_en & ~alt.od & ~pin_oe) == 8'h00)
      else $error("push-pull alternate not driven");
   a_alt_od_hi: assert property ((alt.sel & alt.out_en & alt.od & alt.out_val & pin_oe)
      == 8'h00)
      else $error("open-drain high driven");
   a_alt_od_lo: assert property ((alt.sel & alt.out_en & alt.od & ~alt.out_val & ~pin_oe)
      == 8'h00)
      else $error("open-drain low not driven");
   a_alt_no_pull: assert property ((alt.sel & alt.out_en & pin_pullup) == 8'h00)
      else $error("pull-up on alternate output");
   a_pull_oe: assert property ((pin_pullup & pin_oe) == 8'h00)
      else $error("pull-up on driven pad");
   // Read data stands one cycle only
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside read");
endmodule

bind gpio_port gpio_port_props i_props (.clock(clock), .rst(rst), .addr(addr), .wr(wr),
   .rd(rd), .rdata(rdata), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .alt(alt),
   .cpu_int_mask(cpu_int_mask), .vec_fetch(vec_fetch), .irq_req(irq_req), .wake(wake));

// ---- gpio_port_tb_top.sv ----
`timescale 1ns/1ps
// Bench for the pin port
module gpio_port_tb_top;
   logic                clock, rst, wake;
   logic                wr = 1'b0, rd = 1'b0, cpu_int_mask = 1'b0, ce = 1'b1;
   logic [1:0]          addr = 2'h0, vec_fetch = 2'h0, irq_req;
   logic [7:0]          wdata = 8'h00, ext_val = 8'hff, rdata, lvl, p_out, oe, pu, alt_in;
   gpio_pkg::gpio_alt_t alt = '0;
   int                  err_total = 0, n_compared = 0, cyc = 0;
   gpio_port i_dut (.clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pin_in(lvl), .pin_out(p_out), .pin_oe(oe),
      .pin_pullup(pu), .alt(alt), .alt_in(alt_in), .cpu_int_mask(cpu_int_mask),
      .vec_fetch(vec_fetch), .irq_req(irq_req), .wake(wake));
   gpio_pad_model i_pads (.pin_out(p_out), .pin_oe(oe), .pin_pullup(pu),
      .ext_en(8'hff), .ext_val(ext_val), .clock(clock), .pin_level(lvl));
   task automatic close_out();
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic ext_set(input logic [7:0] v);
      @(posedge clock);
      ext_val <= v;
      repeat (6) @(posedge clock);
      #1;
   endtask
   // Clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Hang guard
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_total++;
         close_out();
      end
   end
   // Main sequence
   initial
   begin
      rst = 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      for (int a = 1; a < 4; a++) rd_chk(a[1:0], 8'h00);
      rd_chk(2'h0, 8'hff);
      wr_reg(2'h0, 8'ha5);
      chk(oe, 8'h00);
      for (int m = 0; m < 4; m++)
      begin
         wr_reg(2'h1, {8{m[1]}});
         wr_reg(2'h2, {8{m[0]}});
         chk(oe, m[1] ? (m[0] ? 8'hff : 8'h5a) : 8'h00);
         chk(pu, (m == 1) ? 8'hff : 8'h00);
      end
      rd_chk(2'h0, 8'ha5);
      chk(lvl, 8'ha5);
      wr_reg(2'h2, 8'h00);
      chk(oe, 8'h5a);
      @(posedge clock);
      alt <= {8'h01, 24'h0};
      ext_set(8'hfe);
      chk({7'h0, alt_in[0]}, 8'h01);
      wr_reg(2'h1, 8'h00);
      @(posedge clock);
      alt <= {8'h30, 8'h30, 8'h20, 8'h20};
      ext_set(8'hdf);
      chk(oe, 8'h10);
      rd_chk(2'h0, 8'hef);
      chk(alt_in, 8'hcf);
      @(posedge clock);
      alt <= '0;
      wr_reg(2'h2, 8'h0f);
      ext_set(8'hff);
      wr_reg(2'h3, 8'h04);
      chk({6'h0, irq_req}, 8'h00);
      ext_set(8'hfb);
      ext_set(8'hff);
      chk({6'h0, irq_req}, 8'h02);
      chk({7'h0, wake}, 8'h01);
      @(posedge clock);
      cpu_int_mask <= 1'b1;
      #1;
      chk({6'h0, irq_req}, 8'h00);
      @(posedge clock);
      cpu_int_mask <= 1'b0;
      vec_fetch <= 2'h2;
      @(posedge clock);
      vec_fetch <= 2'h0;
      #1;
      chk({6'h0, irq_req}, 8'h00);
      ext_set(8'hf7);
      ext_set(8'hff);
      chk({6'h0, irq_req}, 8'h02);
      wr_reg(2'h3, 8'h04);
      chk({6'h0, irq_req}, 8'h00);
      ext_set(8'hfe);
      chk({6'h0, irq_req}, 8'h01);
      // Frozen clock enable must drop the write
      @(posedge clock);
      ce <= 1'b0;
      wr_reg(2'h1, 8'hff);
      @(posedge clock);
      ce <= 1'b1;
      rd_chk(2'h1, 8'h00);
      close_out();
   end
endmodule

// ---- gpio_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels
module gpio_sync #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clock,   // System clock
   input  wire logic             rst,     // Async reset
   input  wire logic             ce,      // Clock enable
   input  wire logic [WIDTH-1:0] din,     // Asynchronous input
   output logic      [WIDTH-1:0] dout     // Synchronised output
);
   logic [WIDTH-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= '1;  // Idle-high pad, no false edge
         dout     <= '1;
      end
      else if (ce)
      begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule
